// ### fpx_class.sv
`timescale 1ns/100ps
module fpx_class (
   input wire logic [63:0] value,
   output fpx_pkg::fpx_class_s cls
);
   logic [10:0] exp_f;
   logic frac_z;
   logic min_neg64;
   logic min_neg32;

   always_comb begin
      exp_f = value[62:52];
      frac_z = (value[51:0] == 52'h0);
      // The most negative integer itself still fits
      min_neg64 = value[63] && (exp_f == fpx_pkg::FPX_EXP_LIM64) && frac_z;
      min_neg32 = value[63] && (exp_f == fpx_pkg::FPX_EXP_LIM32) && (value[51:21] == 31'h0);
      cls.sign = value[63];
      cls.nan = (exp_f == fpx_pkg::FPX_EXP_MAX) && !frac_z;
      cls.snan = cls.nan && !value[51];
      cls.inf = (exp_f == fpx_pkg::FPX_EXP_MAX) && frac_z;
      cls.zero = (exp_f == 11'h000) && frac_z;
      // Before rounding; a value rounding up past the limit is not caught
      cls.big64 = (exp_f >= fpx_pkg::FPX_EXP_LIM64) && !min_neg64;
      cls.big32 = (exp_f >= fpx_pkg::FPX_EXP_LIM32) && !min_neg32;
   end
endmodule : fpx_class

// ### fpx_core_model.sv
`timescale 1ns/100ps
module fpx_core_model (
   input wire logic aclk,
   output fpx_pkg::fpx_op_s op,
   input fpx_pkg::fpx_res_s res
);
   fpx_pkg::fpx_res_s seen;
   initial op = '0;
   task automatic issue(input fpx_pkg::fpx_kind_e k, input logic [63:0] a, input logic [63:0] b);
      @(posedge aclk);
      op <= '{valid: 1'b1, kind: k, a: a, b: b};
      @(posedge aclk);
      // Stale operands flip so they are never mistaken for live data
      op <= '{valid: 1'b0, kind: k, a: ~a, b: ~b};
      #1;
      seen = res;
   endtask : issue
endmodule : fpx_core_model

// ### fpx_default.sv
`timescale 1ns/100ps
module fpx_default (
   input fpx_pkg::fpx_kind_e kind,
   input fpx_pkg::fpx_class_s ca,
   input wire logic b_sign,
   input wire logic zero_div,
   output logic [63:0] value
);
   logic sat_pos;

   always_comb begin
      sat_pos = !ca.sign && !ca.nan;
      if (zero_div) begin
         value = {ca.sign ^ b_sign, fpx_pkg::FPX_PINF[62:0]}; // RL16
      end else if (kind == fpx_pkg::FPX_CVT64) begin
         value = sat_pos ? fpx_pkg::FPX_MAX64 : fpx_pkg::FPX_MIN64; // RL11
      end else if (kind == fpx_pkg::FPX_CVT32) begin
         // High word is undefined; zero is delivered
         value = {32'h0000_0000, sat_pos ? fpx_pkg::FPX_MAX32 : fpx_pkg::FPX_MIN32}; // RL12
      end else begin
         value = fpx_pkg::FPX_QNAN; // RL10
      end
   end
endmodule : fpx_default

// ### fpx_pkg.sv
package fpx_pkg;
   // Register byte offsets
   localparam logic [7:0] FPX_CTRL_OFF = 8'h00;
   localparam logic [7:0] FPX_STAT_OFF = 8'h04;
   localparam logic [7:0] FPX_SREQ_OFF = 8'h08;
   // Control register fields
   localparam int FPX_CTRL_VE = 0;
   localparam int FPX_CTRL_ZE = 1;
   localparam int FPX_CTRL_MLO = 2;
   localparam int FPX_CTRL_MHI = 3;
   localparam logic [3:0] FPX_CTRL_RST = 4'h0;
   // Status and software request register fields
   localparam int FPX_ST_CAUSE = 0;
   localparam int FPX_ST_ZX = 9;
   localparam int FPX_ST_FEX = 10;
   localparam int FPX_ST_FR = 11;
   localparam int FPX_ST_FI = 12;
   localparam int FPX_ST_RESULT_CLASS_FIELD = 13;
   localparam int FPX_SREQ_GO = 0;
   localparam logic [8:0] FPX_CAUSE_RST = 9'h000;
   localparam logic [4:0] FPX_RESULT_CLASS_FIELD_RST = 5'h00;
   // Invalid cause bit positions
   localparam int FPX_C_SNAN = 0;
   localparam int FPX_C_ISI = 1;
   localparam int FPX_C_IDI = 2;
   localparam int FPX_C_ZDZ = 3;
   localparam int FPX_C_IMZ = 4;
   localparam int FPX_C_VC = 5;
   localparam int FPX_C_SOFT = 6;
   localparam int FPX_C_SQRT = 7;
   localparam int FPX_C_CVI = 8;
   // Result class codes
   localparam logic [4:0] FPX_RESULT_CLASS_FIELD_QNAN = 5'h11;
   localparam logic [4:0] FPX_RESULT_CLASS_FIELD_PINF = 5'h05;
   localparam logic [4:0] FPX_RESULT_CLASS_FIELD_NINF = 5'h09;
   localparam logic [3:0] FPX_FP_CONDITION_CODE_UN = 4'h1;
   // Operand encodings
   localparam logic [10:0] FPX_EXP_MAX = 11'h7FF;
   localparam logic [10:0] FPX_EXP_LIM64 = 11'h43E;
   localparam logic [10:0] FPX_EXP_LIM32 = 11'h41E;
   localparam logic [63:0] FPX_QNAN = 64'h7FF8_0000_0000_0000;
   localparam logic [63:0] FPX_PINF = 64'h7FF0_0000_0000_0000;
   localparam logic [63:0] FPX_MAX64 = 64'h7FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] FPX_MIN64 = 64'h8000_0000_0000_0000;
   localparam logic [31:0] FPX_MAX32 = 32'h7FFF_FFFF;
   localparam logic [31:0] FPX_MIN32 = 32'h8000_0000;

   typedef enum logic [3:0] {
      FPX_MOVE = 4'h0,
      FPX_ADD = 4'h1,
      FPX_SUB = 4'h2,
      FPX_MUL = 4'h3,
      FPX_DIV = 4'h4,
      FPX_SQRT = 4'h5,
      FPX_RSQRTE = 4'h6,
      FPX_RES = 4'h7,
      FPX_CMPO = 4'h8,
      FPX_CMPU = 4'h9,
      FPX_CVT64 = 4'hA,
      FPX_CVT32 = 4'hB,
      FPX_RSP = 4'hC
   } fpx_kind_e;

   typedef struct packed {
      logic valid;
      fpx_kind_e kind;
      logic [63:0] a;
      logic [63:0] b;
   } fpx_op_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [63:0] data;
      logic suppress;
      logic prog_exc;
      logic precise;
   } fpx_res_s;

   typedef struct packed {
      logic nan;
      logic snan;
      logic inf;
      logic zero;
      logic sign;
      logic big64;
      logic big32;
   } fpx_class_s;
endpackage : fpx_pkg

// ### fpx_unit.sv
`timescale 1ns/100ps
// Behaviour
// RL1 - Implicit summary set with nonzero mode pair raises program exception
// RL2 - Signaling NaN is invalid except for loads, stores, moves, selects
// RL3 - Infinity subtraction, inf/inf, 0/0, inf*0 are invalid
// RL4 - Ordered compare with NaN: invalid, flags kept, condition code unordered
// RL5 - Root of negative nonzero operand is invalid square root
// RL6 - Integer convert of infinity, NaN or oversized value is invalid
// RL7 - Software request raises invalid condition like hardware
// RL8 - Every invalid case sets one or two specific cause bits
// RL9 - Software request keeps rounding and class values written with it
// RL10 - Invalid arithmetic: flags cleared; enabled keeps target, else quiet NaN
// RL11 - Invalid 64-bit convert disabled: saturate by sign, flags cleared
// RL12 - Invalid 32-bit convert disabled: low word saturated; enabled unchanged
// RL13 - Zero divide for finite nonzero over zero, reciprocal estimates of zero
// RL14 - Zero divide sets sticky bit and clears rounding flags always
// RL15 - Enabled zero divide keeps target and class, sets summary
// RL16 - Disabled zero divide writes signed infinity, class infinity
// RL17 - Later conditions evaluated after exact result; same exception path
// RL18 - Enabled invalid or zero divide suppresses the instruction
// RL19 - Mode pair picks ignore, imprecise or precise handler invocation
// RL20 - Convert may set signaling NaN cause with convert cause
// RL21 - Sticky bits stay set until software clears them
module fpx_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input fpx_pkg::fpx_op_s op,
   output fpx_pkg::fpx_res_s res
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int FPX_CAUSE_HI = fpx_pkg::FPX_ST_CAUSE + 8;
   localparam int FPX_RESULT_CLASS_FIELD_HI = fpx_pkg::FPX_ST_RESULT_CLASS_FIELD + 4;

   // Bus capture
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_do;
   logic [31:0] wd;
   logic wr_ok;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_sreq;
   logic rd_ok;
   logic [31:0] rd_word;
   logic b_done;

   // Control and status state
   logic invalid_enable;
   logic zero_divide_enable;
   logic fp_exc_mode_lo;
   logic fp_exc_mode_hi;
   logic [8:0] cause;
   logic zero_divide_sticky;
   logic enabled_exception_summary;
   logic fraction_rounded_flag;
   logic fraction_inexact_flag;
   logic [4:0] result_class_field;

   // Operation decode
   fpx_pkg::fpx_class_s ca;
   fpx_pkg::fpx_class_s cb;
   logic [63:0] dflt;
   logic two_op;
   logic is_cmp;
   logic is_cvt;
   logic [8:0] hw_cause;
   logic hw_vx;
   logic zd;
   logic soft_req;
   logic vx_en;
   logic zd_en;
   logic fex_set;
   logic mode_on;
   logic [31:0] stat_word;
   logic [8:0] cause_clr;
   logic [8:0] soft_cause;
   logic zx_clr;
   logic fex_clr;

   fpx_class u_class_a (
      .value(op.a),
      .cls(ca)
   );

   fpx_class u_class_b (
      .value(op.b),
      .cls(cb)
   );

   fpx_default u_default (
      .kind(op.kind),
      .ca(ca),
      .b_sign(cb.sign),
      .zero_div(zd),
      .value(dflt)
   );

   // Write side of the register bus
   always_comb begin
      wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
      b_done = s_axi_bvalid && s_axi_bready;
      wd = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         wd[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : 8'h00;
      end
      wr_ctrl = wr_do && (aw_addr[7:2] == fpx_pkg::FPX_CTRL_OFF[7:2]);
      wr_stat = wr_do && (aw_addr[7:2] == fpx_pkg::FPX_STAT_OFF[7:2]);
      wr_sreq = wr_do && (aw_addr[7:2] == fpx_pkg::FPX_SREQ_OFF[7:2]);
      wr_ok = wr_ctrl || wr_stat || wr_sreq;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (b_done) begin
         // Slot reopens only once the response is taken
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (b_done) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read side of the register bus
   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[FPX_CAUSE_HI:fpx_pkg::FPX_ST_CAUSE] = cause;
      stat_word[fpx_pkg::FPX_ST_ZX] = zero_divide_sticky;
      stat_word[fpx_pkg::FPX_ST_FEX] = enabled_exception_summary;
      stat_word[fpx_pkg::FPX_ST_FR] = fraction_rounded_flag;
      stat_word[fpx_pkg::FPX_ST_FI] = fraction_inexact_flag;
      stat_word[FPX_RESULT_CLASS_FIELD_HI:fpx_pkg::FPX_ST_RESULT_CLASS_FIELD] = result_class_field;
      rd_ok = 1'b1;
      unique case (s_axi_araddr[7:2])
         fpx_pkg::FPX_CTRL_OFF[7:2]: begin
            rd_word = {28'h0, fp_exc_mode_hi, fp_exc_mode_lo,
               zero_divide_enable, invalid_enable};
         end
         fpx_pkg::FPX_STAT_OFF[7:2]: begin
            rd_word = stat_word;
         end
         fpx_pkg::FPX_SREQ_OFF[7:2]: begin
            rd_word = 32'h0000_0000;
         end
         default: begin
            rd_word = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         // Data captured at the take, so a later event cannot tear it
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
      end
   end

   // Control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {fp_exc_mode_hi, fp_exc_mode_lo, zero_divide_enable, invalid_enable}
            <= fpx_pkg::FPX_CTRL_RST;
      end else if (wr_ctrl) begin
         invalid_enable <= wd[fpx_pkg::FPX_CTRL_VE];
         zero_divide_enable <= wd[fpx_pkg::FPX_CTRL_ZE];
         fp_exc_mode_lo <= wd[fpx_pkg::FPX_CTRL_MLO];
         fp_exc_mode_hi <= wd[fpx_pkg::FPX_CTRL_MHI];
      end
   end

   // Exception classification
   always_comb begin
      two_op = (op.kind == fpx_pkg::FPX_ADD) || (op.kind == fpx_pkg::FPX_SUB)
         || (op.kind == fpx_pkg::FPX_MUL) || (op.kind == fpx_pkg::FPX_DIV)
         || (op.kind == fpx_pkg::FPX_CMPO) || (op.kind == fpx_pkg::FPX_CMPU);
      is_cmp = (op.kind == fpx_pkg::FPX_CMPO) || (op.kind == fpx_pkg::FPX_CMPU);
      is_cvt = (op.kind == fpx_pkg::FPX_CVT64) || (op.kind == fpx_pkg::FPX_CVT32);
      hw_cause = 9'h000;
      hw_cause[fpx_pkg::FPX_C_SNAN] = (op.kind != fpx_pkg::FPX_MOVE)
         && (ca.snan || (two_op && cb.snan)); // RL2 RL20
      hw_cause[fpx_pkg::FPX_C_ISI] = ca.inf && cb.inf
         && (((op.kind == fpx_pkg::FPX_ADD) && (ca.sign != cb.sign))
         || ((op.kind == fpx_pkg::FPX_SUB) && (ca.sign == cb.sign))); // RL3
      hw_cause[fpx_pkg::FPX_C_IDI] = (op.kind == fpx_pkg::FPX_DIV)
         && ca.inf && cb.inf; // RL3
      hw_cause[fpx_pkg::FPX_C_ZDZ] = (op.kind == fpx_pkg::FPX_DIV)
         && ca.zero && cb.zero; // RL3
      hw_cause[fpx_pkg::FPX_C_IMZ] = (op.kind == fpx_pkg::FPX_MUL)
         && ((ca.inf && cb.zero) || (ca.zero && cb.inf)); // RL3
      hw_cause[fpx_pkg::FPX_C_VC] = (op.kind == fpx_pkg::FPX_CMPO)
         && (ca.nan || cb.nan); // RL4
      hw_cause[fpx_pkg::FPX_C_SQRT] = ((op.kind == fpx_pkg::FPX_SQRT)
         || (op.kind == fpx_pkg::FPX_RSQRTE))
         && ca.sign && !ca.zero && !ca.nan; // RL5
      hw_cause[fpx_pkg::FPX_C_CVI] = is_cvt && (ca.nan || ca.inf
         || ((op.kind == fpx_pkg::FPX_CVT64) ? ca.big64 : ca.big32)); // RL6
      // Idle cycles must not raise causes from stale operands
      if (!op.valid) begin
         hw_cause = 9'h000;
      end
      hw_vx = |hw_cause; // RL8
      zd = op.valid && !hw_vx && (((op.kind == fpx_pkg::FPX_DIV) && cb.zero
         && !ca.zero && !ca.inf && !ca.nan)
         || (((op.kind == fpx_pkg::FPX_RES) || (op.kind == fpx_pkg::FPX_RSQRTE))
         && ca.zero)); // RL13
      soft_req = wr_sreq && wd[fpx_pkg::FPX_SREQ_GO]; // RL7
      vx_en = (hw_vx || soft_req) && invalid_enable;
      zd_en = zd && zero_divide_enable; // RL15
      fex_set = vx_en || zd_en;
      mode_on = fp_exc_mode_hi || fp_exc_mode_lo; // RL19
   end

   // Write-one-to-clear masks and the software cause
   always_comb begin
      cause_clr = wr_stat ? wd[FPX_CAUSE_HI:fpx_pkg::FPX_ST_CAUSE] : 9'h000;
      zx_clr = wr_stat && wd[fpx_pkg::FPX_ST_ZX];
      fex_clr = wr_stat && wd[fpx_pkg::FPX_ST_FEX];
      soft_cause = 9'h000;
      soft_cause[fpx_pkg::FPX_C_SOFT] = soft_req; // RL7
   end

   // Sticky cause bits: a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause <= fpx_pkg::FPX_CAUSE_RST;
         zero_divide_sticky <= 1'b0;
         enabled_exception_summary <= 1'b0;
      end else begin
         cause <= (cause & ~cause_clr) | hw_cause | soft_cause; // RL8 RL21
         zero_divide_sticky <= (zero_divide_sticky && !zx_clr) || zd; // RL14 RL21
         enabled_exception_summary <= (enabled_exception_summary && !fex_clr)
            || fex_set; // RL10 RL15 RL21
      end
   end

   // Rounding flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fraction_rounded_flag <= 1'b0;
         fraction_inexact_flag <= 1'b0;
      end else if ((hw_vx && !is_cmp) || zd) begin
         // Hardware event outranks a software write in the same cycle
         fraction_rounded_flag <= 1'b0; // RL10 RL11 RL14
         fraction_inexact_flag <= 1'b0;
      end else if (wr_stat || wr_sreq) begin
         fraction_rounded_flag <= wd[fpx_pkg::FPX_ST_FR]; // RL9
         fraction_inexact_flag <= wd[fpx_pkg::FPX_ST_FI];
      end
   end

   // Result class field
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_class_field <= fpx_pkg::FPX_RESULT_CLASS_FIELD_RST;
      end else if (hw_vx && is_cmp) begin
         // Condition code is the low four class bits
         result_class_field[3:0] <= fpx_pkg::FPX_FP_CONDITION_CODE_UN; // RL4
      end else if (hw_vx && invalid_enable) begin
         result_class_field <= fpx_pkg::FPX_RESULT_CLASS_FIELD_QNAN; // RL10
      end else if (zd && !zero_divide_enable) begin
         result_class_field <= (ca.sign ^ cb.sign) ? fpx_pkg::FPX_RESULT_CLASS_FIELD_NINF
            : fpx_pkg::FPX_RESULT_CLASS_FIELD_PINF; // RL16
      end else if (!hw_vx && !zd && (wr_stat || wr_sreq)) begin
         result_class_field <= wd[FPX_RESULT_CLASS_FIELD_HI:fpx_pkg::FPX_ST_RESULT_CLASS_FIELD]; // RL9
      end
   end

   // Answer to the pipeline, one cycle after the operation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res <= '0;
      end else begin
         res.valid <= op.valid;
         // Suppressed work keeps every operand intact
         res.suppress <= op.valid && fex_set && !soft_req; // RL18 RL12
         // A compare never delivers a target
         res.write <= !is_cmp && ((hw_vx && !invalid_enable)
            || (zd && !zero_divide_enable)); // RL10 RL11 RL12 RL16
         res.data <= dflt;
         // Exception taken only outside ignore mode
         res.prog_exc <= fex_set && mode_on; // RL1 RL17 RL19
         res.precise <= fp_exc_mode_hi && fp_exc_mode_lo; // RL19
      end
   end
endmodule : fpx_unit

// ### fpx_unit_properties.sv
`timescale 1ns/100ps
module fpx_unit_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input fpx_pkg::fpx_op_s op,
   input fpx_pkg::fpx_res_s res
);
   logic a_inf;
   logic b_inf;
   logic a_nan;
   logic a_zero;
   logic b_zero;
   assign a_inf = op.a[62:0] == fpx_pkg::FPX_PINF[62:0];
   assign b_inf = op.b[62:0] == fpx_pkg::FPX_PINF[62:0];
   assign a_nan = op.a[62:52] == fpx_pkg::FPX_EXP_MAX && op.a[51:0] != 52'h0;
   assign a_zero = op.a[62:0] == 63'h0;
   assign b_zero = op.b[62:0] == 63'h0;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_suppress_no_write: assert property (res.suppress |-> !res.write)
      else $error("suppressed result was written");
   a_precise_raises: assert property (res.suppress && res.precise |-> res.prog_exc)
      else $error("enabled event in precise mode without exception");
   a_div_zero_inf: assert property (op.valid && op.kind == fpx_pkg::FPX_DIV && b_zero
      && !a_zero && op.a[62:52] != fpx_pkg::FPX_EXP_MAX |=> res.suppress || res.write
      && res.data == {$past(op.a[63] ^ op.b[63]), fpx_pkg::FPX_PINF[62:0]})
      else $error("zero divide default result wrong");
   a_cvt64_sat: assert property (op.valid && op.kind == fpx_pkg::FPX_CVT64 && a_inf
      |=> res.suppress || res.write && res.data
      == ($past(op.a[63]) ? fpx_pkg::FPX_MIN64 : fpx_pkg::FPX_MAX64))
      else $error("64-bit convert not saturated");
   a_cvt32_nan_low: assert property (op.valid && op.kind == fpx_pkg::FPX_CVT32 && a_nan
      |=> res.suppress || res.write && res.data[31:0] == fpx_pkg::FPX_MIN32)
      else $error("32-bit convert of NaN not most negative");
   a_inf_sub_qnan: assert property (op.valid && op.kind == fpx_pkg::FPX_SUB && a_inf
      && b_inf && op.a[63] == op.b[63] |=> res.suppress || res.write
      && res.data == fpx_pkg::FPX_QNAN)
      else $error("infinity subtraction not quiet NaN");
   a_sqrt_neg_qnan: assert property (op.valid && op.kind == fpx_pkg::FPX_SQRT && op.a[63]
      && !a_zero && !a_nan |=> res.suppress || res.write && res.data == fpx_pkg::FPX_QNAN)
      else $error("root of negative not quiet NaN");
   a_move_quiet: assert property (op.valid && op.kind == fpx_pkg::FPX_MOVE
      |=> !res.suppress && !res.prog_exc)
      else $error("move raised an exception");
   a_cmp_no_write: assert property (op.valid && op.kind inside {fpx_pkg::FPX_CMPO,
      fpx_pkg::FPX_CMPU} |=> !res.write)
      else $error("compare wrote a target");
endmodule : fpx_unit_properties

bind fpx_unit fpx_unit_properties u_props (.aclk, .aresetn, .op, .res);

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
   localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
   localparam logic [63:0] NEG1 = 64'hBFF0_0000_0000_0000;
   localparam logic [63:0] PINF = 64'h7FF0_0000_0000_0000;
   localparam logic [63:0] NINF = 64'hFFF0_0000_0000_0000;
   localparam logic [63:0] SNAN = 64'h7FF4_0000_0000_0000;
   localparam logic [63:0] QNAN = 64'h7FF8_0000_0000_0000;
   localparam logic [63:0] NZERO = 64'h8000_0000_0000_0000;
   localparam logic [63:0] BIG = 64'h43F0_0000_0000_0000;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr;
   logic awvalid;
   logic awready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wvalid;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready;
   logic [7:0] araddr;
   logic arvalid;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready;
   logic [31:0] rd_data;
   logic [1:0] rsp;
   fpx_pkg::fpx_op_s op;
   fpx_pkg::fpx_res_s res;
   int fail_count;
   int num_checks;

   fpx_unit u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .op(op), .res(res));
   fpx_core_model u_core (.aclk(aclk), .op(op), .res(res));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize

   // Ready is registered, so the negedge sample tells what the next edge takes
   task automatic axw(input logic [7:0] ad, input logic [31:0] d);
      logic a_go;
      logic w_go;
      logic b_go;
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_go = 1'b0;
      while (!b_go) begin
         @(negedge aclk);
         a_go = awvalid && awready;
         w_go = wvalid && wready;
         b_go = bvalid;
         rsp = bresp;
         @(posedge aclk);
         if (a_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] ad);
      logic a_go;
      logic r_go;
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_go = 1'b0;
      while (!r_go) begin
         @(negedge aclk);
         a_go = arvalid && arready;
         r_go = rvalid;
         rd_data = rdata;
         rsp = rresp;
         @(posedge aclk);
         if (a_go) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : axr

   // Flags are write, suppress, exception; status is bits 17:0
   task automatic run(input fpx_pkg::fpx_kind_e k, input logic [63:0] a, input logic [63:0] b,
         input logic [2:0] fl, input logic [63:0] d, input logic [17:0] st);
      axw(fpx_pkg::FPX_STAT_OFF, 32'h0000_07FF);
      u_core.issue(k, a, b);
      check("flags", 64'({u_core.seen.write, u_core.seen.suppress, u_core.seen.prog_exc}),
         64'(fl));
      check("valid", 64'(u_core.seen.valid), 64'h1);
      if (fl[2]) check("data", u_core.seen.data, d);
      axr(fpx_pkg::FPX_STAT_OFF);
      check("status", 64'(rd_data[17:0]), 64'(st));
   endtask : run

   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      summarize();
   end

   initial begin
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      wstrb = 4'hF;
      fail_count = 0;
      num_checks = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axr(fpx_pkg::FPX_STAT_OFF);
      check("stat_rst", 64'(rd_data), 64'h0);
      axr(8'h0C);
      check("unmapped", 64'({rsp, rd_data}), 64'h2_0000_0000);
      axw(8'h0C, 32'h0000_0001);
      check("unmapped_wr", 64'(rsp), 64'h2);
      axw(fpx_pkg::FPX_CTRL_OFF, 32'h0000_000F);
      check("wr_resp", 64'(rsp), 64'h0);
      axr(fpx_pkg::FPX_CTRL_OFF);
      check("ctrl", 64'(rd_data[3:0]), 64'hF);
      axw(fpx_pkg::FPX_CTRL_OFF, 32'h0);
      run(fpx_pkg::FPX_ADD, PINF, NINF, 3'b100, QNAN, 18'h00002);
      run(fpx_pkg::FPX_SUB, PINF, PINF, 3'b100, QNAN, 18'h00002);
      run(fpx_pkg::FPX_DIV, PINF, NINF, 3'b100, QNAN, 18'h00004);
      run(fpx_pkg::FPX_DIV, 64'h0, NZERO, 3'b100, QNAN, 18'h00008);
      run(fpx_pkg::FPX_MUL, NINF, 64'h0, 3'b100, QNAN, 18'h00010);
      run(fpx_pkg::FPX_ADD, SNAN, ONE, 3'b100, QNAN, 18'h00001);
      run(fpx_pkg::FPX_RSP, SNAN, 64'h0, 3'b100, QNAN, 18'h00001);
      run(fpx_pkg::FPX_MOVE, SNAN, 64'h0, 3'b000, 64'h0, 18'h00000);
      run(fpx_pkg::FPX_SQRT, NEG1, 64'h0, 3'b100, QNAN, 18'h00080);
      run(fpx_pkg::FPX_RSQRTE, NEG1, 64'h0, 3'b100, QNAN, 18'h00080);
      run(fpx_pkg::FPX_CVT64, PINF, 64'h0, 3'b100, fpx_pkg::FPX_MAX64, 18'h00100);
      run(fpx_pkg::FPX_CVT64, NINF, 64'h0, 3'b100, fpx_pkg::FPX_MIN64, 18'h00100);
      run(fpx_pkg::FPX_CVT64, BIG, 64'h0, 3'b100, fpx_pkg::FPX_MAX64, 18'h00100);
      run(fpx_pkg::FPX_CVT32, QNAN, 64'h0, 3'b100, 64'h8000_0000, 18'h00100);
      run(fpx_pkg::FPX_CMPO, QNAN, ONE, 3'b000, 64'h0, 18'h02020);
      run(fpx_pkg::FPX_CMPU, SNAN, ONE, 3'b000, 64'h0, 18'h02001);
      run(fpx_pkg::FPX_DIV, ONE, NZERO, 3'b100, NINF, 18'h12200);
      run(fpx_pkg::FPX_RSQRTE, 64'h0, 64'h0, 3'b100, PINF, 18'h0A200);
      u_core.issue(fpx_pkg::FPX_ADD, ONE, ONE);
      axr(fpx_pkg::FPX_STAT_OFF);
      check("sticky", 64'(rd_data[9]), 64'h1);
      axw(fpx_pkg::FPX_CTRL_OFF, 32'h0000_0005);
      run(fpx_pkg::FPX_ADD, PINF, NINF, 3'b011, 64'h0, 18'h22402);
      run(fpx_pkg::FPX_CVT32, PINF, 64'h0, 3'b011, 64'h0, 18'h22500);
      axw(fpx_pkg::FPX_SREQ_OFF, 32'h0000_A801);
      axr(fpx_pkg::FPX_STAT_OFF);
      check("soft", 64'(rd_data[17:0]), 64'h0AD40);
      axw(fpx_pkg::FPX_CTRL_OFF, 32'h0000_0009);
      run(fpx_pkg::FPX_MUL, PINF, 64'h0, 3'b011, 64'h0, 18'h22410);
      check("imprecise", 64'(u_core.seen.precise), 64'h0);
      axw(fpx_pkg::FPX_CTRL_OFF, 32'h0000_000E);
      run(fpx_pkg::FPX_DIV, ONE, 64'h0, 3'b011, 64'h0, 18'h00600);
      check("precise", 64'(u_core.seen.precise), 64'h1);
      axw(fpx_pkg::FPX_CTRL_OFF, 32'h0000_0002);
      run(fpx_pkg::FPX_RES, 64'h0, 64'h0, 3'b010, 64'h0, 18'h00600);
      summarize();
   end
endmodule : tb_top
